// [src/motion_cfg_pkg.sv]
// package for the servo motion configuration logic
// assumes one clock domain and registers reached over apb
package motion_cfg_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_EMU = 8'h04;
	localparam logic [7:0] OFS_GEAR = 8'h08;
	localparam logic [7:0] OFS_LIMIT = 8'h0C;
	localparam logic [7:0] OFS_LOOP = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_POS = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_OUT = 8'h20;
	// cfg field positions
	localparam int CFG_POLES_LSB = 0;
	localparam int CFG_CCW_EN = 8;
	localparam int CFG_CW_EN = 9;
	localparam int CFG_FEEDBACK_SOURCE_SELECT = 10;
	localparam int CFG_BLINK = 11;
	localparam int CFG_CLRSTYLE = 12;
	localparam int CFG_POSSRC = 13;
	localparam int CFG_FASTINV = 14;
	localparam int CFG_OCPOL = 15;
	localparam int CFG_MODE_LSB = 16;
	localparam int CFG_SWITCH_LSB = 20;
	localparam int CFG_LSEL_LSB = 24;
	// reset values and fixed constants
	localparam logic [31:0] CFG_RST = 32'h0000_B100;
	localparam logic [31:0] EMU_RST = 32'h0000_8000;
	localparam logic [31:0] GEAR_RST = 32'h0100_0100;
	localparam logic [31:0] LIMIT_RST = 32'h0064_6464;
	localparam logic [3:0] LSEL_PROG = 4'hE;
	localparam logic [7:0] FOLD_PCT = 8'h43;
	localparam logic [15:0] KVI_MIN_CODE = 16'h0013;
	localparam logic [15:0] KVI_MIN = 16'h0013;
	localparam int BLINK_HALF = 64;
	localparam logic [7:0] PCT_FULL = 8'h64;
	typedef enum logic [1:0] {MODE_CUR = 2'b00, MODE_VEL = 2'b01, MODE_POS = 2'b11} mode_e;
	typedef enum logic [1:0] {BL_IDLE = 2'b00, BL_HIGH = 2'b01, BL_LOW = 2'b11, BL_GAP = 2'b10} blink_e;
	typedef struct packed {
		logic [3:0] rsvd;
		logic [3:0] line_sel;
		logic [3:0] rot_switch;
		logic [1:0] rsvd2;
		logic [1:0] mode;
		logic oc_policy;
		logic fast_inv;
		logic pos_src;
		logic clr_style;
		logic blink_en;
		logic fb_src;
		logic cw_en;
		logic ccw_en;
		logic [1:0] rsvd3;
		logic [5:0] poles;
	} cfg_s;
endpackage : motion_cfg_pkg

// [src/servo_drive_motion_config.sv]
// configuration driven motion logic: emulated encoder, inhibit clamp, gearing, fault line
// assumes pins synchronous to pclk except the enable, which is synchronised here
`timescale 1ns/1ps
// Functional notes
// RULE_01: pole code n means 2n poles, zero off
// RULE_02: switch zero plus code picks line count
// RULE_03: quadrature counts are four times lines
// RULE_04: custom count used only with programmable code
// RULE_05: zero custom count suppresses marker
// RULE_06: marker uses feedback minus offset
// RULE_07: ccw block clamps command nonnegative
// RULE_08: cw block clamps command nonpositive
// RULE_09: both blocks force command zero
// RULE_10: option feedback zeros base position, sine
// RULE_11: angle offset write moves reported position; code applies the offset only on option feedback
// RULE_12: blink mode toggles fault line n times
// RULE_13: faults clear on edge or level
// RULE_14: gear ratio multiplier over divisor over 256; code multiplies by 256 after the divisor instead
// RULE_15: one count per step or quadrature count
// RULE_16: negative multiplier reverses motion
// RULE_17: fast input inverted when bit set
// RULE_18: overcurrent faults or folds to 67 percent
// RULE_19: separate cw and ccw current limits
// RULE_20: velocity is gain error plus feedforward
// RULE_21: integral break below 0.19 Hz disables integral
// RULE_22: enable synchronised, edge detected
module servo_drive_motion_config import motion_cfg_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hw_enable_input,
	input wire logic ccw_block_input,
	input wire logic cw_block_input,
	input wire logic fast_input_one,
	input wire logic step_in,
	input wire logic dir_in,
	input wire logic quad_a,
	input wire logic quad_b,
	input wire logic [15:0] base_position,
	input wire logic [15:0] option_position,
	input wire logic overcurrent_event,
	input wire logic fault_event,
	input wire logic [3:0] fault_code,
	output logic fault_output_line,
	output logic marker_pulse,
	output logic commutation_enable,
	output logic sine_commutation,
	output logic base_feedback_enable,
	output logic fast_input_used,
	output logic signed [15:0] motion_command,
	output logic integral_enable
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	cfg_s cfg_r;
	logic [31:0] emu_r, gear_r, limit_r, loop_r, pos_cmd_r, pos_prev_r;
	logic signed [15:0] cmd_r, comm_offset_r, vel_cmd_r, raw_cmd, lim_cmd;
	logic [15:0] position_feedback_r, lines, marker_pos;
	logic fault_r, folded_r, en_s1_r, en_s2_r, en_prev_r, qa_r, qb_r, step_prev_r;
	blink_e bl_r;
	logic [7:0] bl_tmr_r, lim_cw, lim_ccw;
	logic [3:0] bl_cnt_r;
	logic wr_en, rd_en, en_rise, enabled, marker_allowed;
	logic [17:0] quad_counts;
	logic signed [1:0] in_step;
	logic signed [31:0] position_error;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// fixed line table for selector codes, code 14 handled by caller
	function automatic logic [15:0] line_table(input logic [3:0] code);
		logic [15:0] v;
		v = 16'h01F4;
		unique case (code)
			4'h0: v = 16'h01F4;
			4'h1: v = 16'h0200;
			4'h2: v = 16'h03E8;
			4'h3: v = 16'h0400;
			4'h4: v = 16'h07D0;
			4'h5: v = 16'h0800;
			4'h6: v = 16'h1000;
			4'h7: v = 16'h1388;
			4'h8: v = 16'h2000;
			4'h9: v = 16'h2710;
			4'hA: v = 16'h007D;
			4'hB: v = 16'h0080;
			4'hC: v = 16'h4000;
			4'hD: v = 16'h4E20;
			4'hE: v = 16'h8000;
			4'hF: v = 16'h09C4;
		endcase
		return v;
	endfunction : line_table

	// clamp level: pct percent of positive full scale 32767
	function automatic logic signed [15:0] pct_of(input logic [7:0] pct);
		logic [23:0] p;
		p = 24'(pct) * 24'h007FFF;
		return 16'(p / 24'(PCT_FULL));
	endfunction : pct_of

	// ----------------------------------------------------------------
	// apb slave: zero wait, offsets above OFS_OUT read zero with error
	// ----------------------------------------------------------------
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;

	assign pslverr = psel && penable && paddr > OFS_OUT;

	// software written configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= CFG_RST;
			emu_r <= EMU_RST;
			gear_r <= GEAR_RST;
			limit_r <= LIMIT_RST;
			loop_r <= 32'h0000_0000;
			cmd_r <= 16'sh0000;
			comm_offset_r <= 16'sh0000;
		end else if (wr_en) begin
			unique case (paddr)
				OFS_CFG: cfg_r <= pwdata;
				OFS_EMU: emu_r <= pwdata;
				OFS_GEAR: gear_r <= pwdata;
				OFS_LIMIT: limit_r <= pwdata;
				OFS_LOOP: loop_r <= pwdata;
				OFS_CMD: cmd_r <= pwdata[15:0];
				OFS_POS: comm_offset_r <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// read mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && !penable) begin
			unique case (paddr)
				OFS_CFG: prdata <= cfg_r;
				OFS_EMU: prdata <= emu_r;
				OFS_GEAR: prdata <= gear_r;
				OFS_LIMIT: prdata <= limit_r;
				OFS_LOOP: prdata <= loop_r;
				OFS_CMD: prdata <= {16'h0000, cmd_r};
				OFS_POS: prdata <= {position_feedback_r, comm_offset_r};
				OFS_STATUS: prdata <= {14'h0000, quad_counts};
				OFS_OUT: prdata <= {vel_cmd_r, 13'h0000, folded_r, fault_r, enabled};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// enable sync and fault clearing
	// ----------------------------------------------------------------
	// enable is active low at the pin, so enabled means pin low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
			en_prev_r <= 1'b0;
		end else begin
			en_s1_r <= !hw_enable_input; // [RULE_22]
			en_s2_r <= en_s1_r;
			en_prev_r <= en_s2_r;
		end
	end
	assign enabled = en_s2_r;
	assign en_rise = en_s2_r && !en_prev_r; // [RULE_22]

	// fault latch: a new fault wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_r <= 1'b0;
		end else if (fault_event || (overcurrent_event && !cfg_r.oc_policy)) begin
			fault_r <= 1'b1; // [RULE_18]
		end else if (cfg_r.clr_style ? !enabled : en_rise) begin
			fault_r <= 1'b0; // [RULE_13]
		end
	end

	// foldback stays until faults are cleared the same way
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			folded_r <= 1'b0;
		end else if (overcurrent_event && cfg_r.oc_policy) begin
			folded_r <= 1'b1; // [RULE_18]
		end else if (cfg_r.clr_style ? !enabled : en_rise) begin
			folded_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// commutation, feedback and emulated encoder
	// ----------------------------------------------------------------
	assign commutation_enable = cfg_r.poles != 6'h00; // [RULE_01]
	assign sine_commutation = cfg_r.fb_src; // [RULE_10]
	assign base_feedback_enable = !cfg_r.fb_src; // [RULE_10]
	assign fast_input_used = fast_input_one ^ cfg_r.fast_inv; // [RULE_17]
	assign integral_enable = loop_r[15:0] >= KVI_MIN; // [RULE_21]

	// reported position: option word plus offset on option feedback, base word otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			position_feedback_r <= 16'h0000;
		end else if (cfg_r.fb_src) begin
			position_feedback_r <= option_position + comm_offset_r; // [RULE_11]
		end else begin
			position_feedback_r <= base_position; // [RULE_10]
		end
	end

	// line count: only switch 0 uses the selector, only code 14 the custom count
	always_comb begin
		lines = 16'h8000;
		if (cfg_r.rot_switch == 4'h0) begin
			lines = (cfg_r.line_sel == LSEL_PROG) ? emu_r[15:0] : line_table(cfg_r.line_sel); // [RULE_02] [RULE_04]
		end
	end
	assign quad_counts = {lines, 2'b00}; // [RULE_03]
	assign marker_allowed = !(cfg_r.rot_switch == 4'h0 && cfg_r.line_sel == LSEL_PROG && emu_r[15:0] == 16'h0000);
	assign marker_pos = position_feedback_r - emu_r[31:16]; // [RULE_06]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			marker_pulse <= 1'b0;
		end else begin
			marker_pulse <= marker_allowed && marker_pos == 16'h0000; // [RULE_05]
		end
	end

	// ----------------------------------------------------------------
	// position command and gearing
	// ----------------------------------------------------------------
	always_comb begin
		in_step = 2'sb00;
		if (cfg_r.pos_src) begin
			if (step_in && !step_prev_r) begin
				in_step = dir_in ? -2'sd1 : 2'sd1; // [RULE_15]
			end
		end else if (quad_a != qa_r || quad_b != qb_r) begin
			in_step = ((qa_r ^ quad_b) != 1'b0) ? 2'sd1 : -2'sd1; // [RULE_15]
		end
	end

	// command accumulates multiplier per count; divisor and times 256 applied on use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_cmd_r <= 32'h0000_0000;
			pos_prev_r <= 32'h0000_0000;
			step_prev_r <= 1'b0;
			qa_r <= 1'b0;
			qb_r <= 1'b0;
		end else begin
			step_prev_r <= step_in;
			qa_r <= quad_a;
			qb_r <= quad_b;
			pos_prev_r <= pos_cmd_r;
			// sign of multiplier sets direction
			pos_cmd_r <= pos_cmd_r + 32'($signed(in_step) * $signed(gear_r[31:16])); // [RULE_14] [RULE_16]
		end
	end

	// error in feedback units; a zero divisor holds the error at zero
	always_comb begin
		position_error = 32'sh0000_0000;
		if (gear_r[15:0] != 16'h0000) begin
			position_error = 32'($signed(pos_cmd_r) / $signed({16'h0000, gear_r[15:0]}) * 256
				- $signed({16'h0000, position_feedback_r})); // [RULE_14]
		end
	end

	// position loop: gain*2pi*err + ff/100 * d/dt cmd; 2pi approximated as 201/32
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vel_cmd_r <= 16'sh0000;
		end else begin
			// gain and feedforward are unsigned codes, zero-extended so 199 percent stays positive
			vel_cmd_r <= 16'(($signed({1'b0, loop_r[23:16]}) * position_error * 201) / 32
				+ ($signed({1'b0, loop_r[31:24]}) * $signed(pos_cmd_r - pos_prev_r)) / 100); // [RULE_20]
		end
	end

	// ----------------------------------------------------------------
	// limits and inhibit clamp
	// ----------------------------------------------------------------
	assign lim_cw = (folded_r && limit_r[7:0] > FOLD_PCT) ? FOLD_PCT : limit_r[7:0]; // [RULE_18] [RULE_19]
	assign lim_ccw = (folded_r && limit_r[15:8] > FOLD_PCT) ? FOLD_PCT : limit_r[15:8]; // [RULE_19]
	assign raw_cmd = (cfg_r.mode == MODE_POS) ? vel_cmd_r : cmd_r;

	always_comb begin
		lim_cmd = raw_cmd;
		if (cfg_r.mode == MODE_CUR && raw_cmd > pct_of(lim_cw)) begin
			lim_cmd = pct_of(lim_cw); // [RULE_19]
		end
		if (cfg_r.mode == MODE_CUR && raw_cmd < -pct_of(lim_ccw)) begin
			lim_cmd = -pct_of(lim_ccw); // [RULE_19]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motion_command <= 16'sh0000;
		end else if (cfg_r.ccw_en && ccw_block_input && cfg_r.cw_en && cw_block_input) begin
			motion_command <= 16'sh0000; // [RULE_09]
		end else if (cfg_r.ccw_en && ccw_block_input && lim_cmd < 0) begin
			motion_command <= 16'sh0000; // [RULE_07]
		end else if (cfg_r.cw_en && cw_block_input && lim_cmd > 0) begin
			motion_command <= 16'sh0000; // [RULE_08]
		end else begin
			motion_command <= lim_cmd;
		end
	end

	// ----------------------------------------------------------------
	// fault output blink coder
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bl_r <= BL_IDLE;
			bl_tmr_r <= 8'h00;
			bl_cnt_r <= 4'h0;
		end else begin
			bl_tmr_r <= (bl_tmr_r == 8'(BLINK_HALF - 1)) ? 8'h00 : bl_tmr_r + 8'h01;
			if (bl_tmr_r == 8'(BLINK_HALF - 1)) begin
				unique case (bl_r)
					BL_IDLE: begin
						if (fault_r && cfg_r.blink_en && fault_code != 4'h0) begin
							bl_r <= BL_HIGH;
							bl_cnt_r <= fault_code;
						end
					end
					BL_HIGH: bl_r <= BL_LOW;
					BL_LOW: begin
						bl_cnt_r <= bl_cnt_r - 4'h1;
						bl_r <= (bl_cnt_r == 4'h1) ? BL_GAP : BL_HIGH;
					end
					BL_GAP: bl_r <= BL_IDLE;
				endcase
			end
		end
	end

	// drive off always static high; blink only toggles while enabled and faulted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_output_line <= 1'b1;
		end else if (!enabled) begin
			fault_output_line <= 1'b1; // [RULE_12]
		end else if (cfg_r.blink_en && fault_r) begin
			fault_output_line <= (bl_r == BL_HIGH); // [RULE_12]
		end else begin
			fault_output_line <= fault_r;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_both_block_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
		cfg_r.ccw_en && ccw_block_input && cfg_r.cw_en && cw_block_input |=> motion_command == 16'sh0000)
		else $error("both inhibits active but command not zero");
	chk_ccw_nonneg: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
		cfg_r.ccw_en && ccw_block_input |=> motion_command >= 0)
		else $error("ccw inhibit let negative command through");
	chk_cw_nonpos: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
		cfg_r.cw_en && cw_block_input |=> motion_command <= 0)
		else $error("cw inhibit let positive command through");
	chk_off_fault_high: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
		!enabled |=> fault_output_line)
		else $error("fault line not high while drive off");
	chk_level_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
		cfg_r.clr_style && !enabled && !fault_event && !overcurrent_event |=> !fault_r)
		else $error("level style did not clear fault");
	chk_enable_edge: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_22]
		!hw_enable_input ##1 !hw_enable_input ##1 !hw_enable_input |-> enabled)
		else $error("enable sync latency wrong");
	chk_marker_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
		!marker_allowed |=> !marker_pulse)
		else $error("marker not suppressed");
	chk_fast_invert: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_17]
		fast_input_used == (cfg_r.fast_inv ? !fast_input_one : fast_input_one))
		else $error("fast input polarity wrong");
	chk_quad_four: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
		cfg_r.rot_switch == 4'h0 && cfg_r.line_sel == 4'h0 |-> quad_counts == 18'd2000)
		else $error("quadrature count not four times lines");
endmodule : servo_drive_motion_config

// [tb/motion_partner.sv]
// far side model: feedback device on a shaft turning at a fixed rate
// assumes pclk and presetn come from the bench
`timescale 1ns/1ps
module motion_partner (
	input wire logic pclk,
	input wire logic presetn,
	output logic [15:0] base_position,
	output logic [15:0] option_position,
	output logic quad_a,
	output logic quad_b
);
	// 64 counts a cycle, so the base word wraps every 1024 cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_position <= 16'h0000;
		end else begin
			base_position <= base_position + 16'h0040;
		end
	end
	// option word held still so an offset move is the only change
	assign option_position = 16'h2468;
	// gray sequence 00 01 11 10, a legal quadrature walk
	assign quad_a = base_position[7];
	assign quad_b = base_position[7] ^ base_position[6];
endmodule : motion_partner

// [tb/servo_drive_motion_config_tb.sv]
// bench for the motion configuration block: apb tasks, one task per scenario
// assumes the package, the design and the partner model are compiled first
`timescale 1ns/1ps
module servo_drive_motion_config_tb import motion_cfg_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic hw_enable_input, ccw_block_input, cw_block_input, fast_input_one, step_in, dir_in;
	logic quad_a, quad_b, overcurrent_event, fault_event;
	logic [3:0] fault_code;
	logic [15:0] base_position, option_position, pa, pb;
	logic fault_output_line, marker_pulse, commutation_enable, sine_commutation;
	logic base_feedback_enable, fast_input_used, integral_enable, ha, hb;
	logic signed [15:0] motion_command;
	int fail_count, samples_checked;
	int lines[16] = '{500, 512, 1000, 1024, 2000, 2048, 4096, 5000,
		8192, 10000, 125, 128, 16384, 20000, 32768, 2500};

	servo_drive_motion_config u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_enable_input(hw_enable_input), .ccw_block_input(ccw_block_input),
		.cw_block_input(cw_block_input), .fast_input_one(fast_input_one), .step_in(step_in),
		.dir_in(dir_in), .quad_a(quad_a), .quad_b(quad_b), .base_position(base_position),
		.option_position(option_position), .overcurrent_event(overcurrent_event),
		.fault_event(fault_event), .fault_code(fault_code), .fault_output_line(fault_output_line),
		.marker_pulse(marker_pulse), .commutation_enable(commutation_enable),
		.sine_commutation(sine_commutation), .base_feedback_enable(base_feedback_enable),
		.fast_input_used(fast_input_used), .motion_command(motion_command),
		.integral_enable(integral_enable));
	motion_partner u_far (.pclk(pclk), .presetn(presetn), .base_position(base_position),
		.option_position(option_position), .quad_a(quad_a), .quad_b(quad_b));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	always #2 pclk = ~pclk;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wait_cmd(input logic [15:0] exp);
		int n;
		for (n = 0; n < 20 && motion_command !== exp; n++) @(negedge pclk);
		check("motion_command", {16'h0000, exp}, {16'h0000, motion_command});
		@(posedge pclk);
	endtask : wait_cmd

	task automatic wait_fault(input logic exp);
		int n;
		for (n = 0; n < 20 && fault_output_line !== exp; n++) @(negedge pclk);
		check("fault_output_line", {31'h0, exp}, {31'h0, fault_output_line});
		@(posedge pclk);
	endtask : wait_fault

	// first marker rise after the write; base word at that moment
	task automatic marker_at(input logic [31:0] emu, output logic [15:0] p, output logic hit);
		logic prev;
		int n;
		apb(1'b1, OFS_EMU, emu);
		hit = 1'b0;
		p = 16'h0000;
		prev = 1'b1;
		for (n = 0; n < 2200 && !hit; n++) begin
			@(negedge pclk);
			if (marker_pulse === 1'b1 && prev === 1'b0) begin
				hit = 1'b1;
				p = base_position;
			end
			prev = marker_pulse;
		end
		@(posedge pclk);
	endtask : marker_at

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		apb(1'b0, OFS_CFG, 32'h0);
		check("cfg", CFG_RST, rd);
		apb(1'b0, OFS_EMU, 32'h0);
		check("emu", EMU_RST, rd);
		apb(1'b0, OFS_GEAR, 32'h0);
		check("gear", GEAR_RST, rd);
		apb(1'b0, 8'h24, 32'h0);
		check("unmapped err", 32'h1, {31'h0, err});
		check("unmapped data", 32'h0, rd);
		$display("test regs done");
	endtask : t_regs

	// every line code with the switch at zero, then the largest custom count and a nonzero switch
	task automatic t_lines();
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, OFS_CFG, {4'h0, c[3:0], 24'h0});
			apb(1'b0, OFS_STATUS, 32'h0);
			check("quad counts", 32'(4 * lines[c]), rd);
		end
		apb(1'b1, OFS_CFG, 32'h0E00_0000);
		apb(1'b1, OFS_EMU, 32'h0000_FFFF);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("custom counts", 32'd262140, rd);
		apb(1'b1, OFS_CFG, 32'h0E10_0000);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("switch off zero", 32'h1, {31'h0, rd !== 32'd262140});
		$display("test lines done");
	endtask : t_lines

	task automatic t_marker();
		apb(1'b1, OFS_CFG, 32'h0E00_0000);
		marker_at(32'h0000_0000, pa, ha);
		check("marker off", 32'h0, {31'h0, ha});
		marker_at(32'h0000_8000, pa, ha);
		marker_at(32'h8000_8000, pb, hb);
		check("marker seen", 32'h1, {31'h0, ha & hb});
		check("marker moved", 32'h8000, {16'h0, pb - pa});
		$display("test marker done");
	endtask : t_marker

	task automatic t_static();
		apb(1'b1, OFS_CFG, 32'h0000_0000);
		check("commutation off", 32'h0, {31'h0, commutation_enable});
		apb(1'b1, OFS_CFG, 32'h0000_041F);
		check("commutation on", 32'h1, {31'h0, commutation_enable});
		check("sine", 32'h1, {31'h0, sine_commutation});
		check("base fb off", 32'h0, {31'h0, base_feedback_enable});
		apb(1'b0, OFS_POS, 32'h0);
		pa = rd[31:16];
		apb(1'b1, OFS_POS, 32'h0000_1000);
		apb(1'b0, OFS_POS, 32'h0);
		check("offset moves pos", 32'h1, {31'h0, rd[31:16] !== pa});
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, OFS_CFG, {17'h0, k[1], 14'h0});
			fast_input_one <= k[0];
			@(negedge pclk);
			check("fast input", {31'h0, k[0] ^ k[1]}, {31'h0, fast_input_used});
			@(posedge pclk);
		end
		apb(1'b1, OFS_LOOP, 32'h0000_0012);
		check("integral off", 32'h0, {31'h0, integral_enable});
		apb(1'b1, OFS_LOOP, 32'h0000_0013);
		check("integral on", 32'h1, {31'h0, integral_enable});
		$display("test static done");
	endtask : t_static

	// velocity mode keeps the current limits out of the way
	task automatic t_inhibit();
		hw_enable_input <= 1'b0;
		apb(1'b1, OFS_CFG, 32'h0001_0300);
		apb(1'b1, OFS_CMD, 32'h0000_FF9C);
		wait_cmd(16'hFF9C);
		ccw_block_input <= 1'b1;
		wait_cmd(16'h0000);
		apb(1'b1, OFS_CMD, 32'h0000_0064);
		wait_cmd(16'h0064);
		ccw_block_input <= 1'b0;
		cw_block_input <= 1'b1;
		wait_cmd(16'h0000);
		apb(1'b1, OFS_CMD, 32'h0000_FF9C);
		wait_cmd(16'hFF9C);
		ccw_block_input <= 1'b1;
		wait_cmd(16'h0000);
		apb(1'b1, OFS_CFG, 32'h0001_0000);
		wait_cmd(16'hFF9C);
		$display("test inhibit done");
	endtask : t_inhibit

	task automatic t_fault();
		int lo, hi;
		lo = 0;
		hi = 0;
		apb(1'b1, OFS_CFG, 32'h0000_1800);
		wait_fault(1'b0);
		fault_event <= 1'b1;
		@(posedge pclk);
		fault_event <= 1'b0;
		repeat (400) begin
			@(negedge pclk);
			lo += !fault_output_line;
			hi += fault_output_line;
		end
		check("blinking", 32'h1, {31'h0, lo > 0 && hi > 0});
		@(posedge pclk);
		hw_enable_input <= 1'b1;
		repeat (10) @(posedge pclk);
		apb(1'b0, OFS_OUT, 32'h0);
		check("level clear", 32'h0, {31'h0, rd[1]});
		lo = 0;
		repeat (300) begin
			@(negedge pclk);
			lo += !fault_output_line;
		end
		check("off static high", 32'h0, 32'(lo));
		@(posedge pclk);
		hw_enable_input <= 1'b0;
		wait_fault(1'b0);
		apb(1'b1, OFS_CFG, 32'h0000_0000);
		fault_event <= 1'b1;
		@(posedge pclk);
		fault_event <= 1'b0;
		wait_fault(1'b1);
		hw_enable_input <= 1'b1;
		repeat (10) @(posedge pclk);
		apb(1'b0, OFS_OUT, 32'h0);
		check("edge style holds fault", 32'h1, {31'h0, rd[1]});
		hw_enable_input <= 1'b0;
		wait_fault(1'b0);
		$display("test fault done");
	endtask : t_fault

	// current mode limits, foldback that spares a limit already low, then the fault policy
	task automatic t_limits();
		apb(1'b1, OFS_CFG, 32'h0000_8000);
		apb(1'b1, OFS_LIMIT, 32'h0000_3264);
		apb(1'b1, OFS_CMD, 32'h0000_8001);
		wait_cmd(16'(-(32767 * 50 / 100)));
		apb(1'b1, OFS_CMD, 32'h0000_7FFF);
		wait_cmd(16'h7FFF);
		overcurrent_event <= 1'b1;
		@(posedge pclk);
		overcurrent_event <= 1'b0;
		wait_cmd(16'(32767 * int'(FOLD_PCT) / int'(PCT_FULL)));
		apb(1'b1, OFS_CMD, 32'h0000_8001);
		wait_cmd(16'(-(32767 * 50 / 100)));
		apb(1'b0, OFS_OUT, 32'h0);
		check("folded no fault", 32'h5, {29'h0, rd[2:0]});
		apb(1'b1, OFS_CFG, 32'h0000_0000);
		overcurrent_event <= 1'b1;
		@(posedge pclk);
		overcurrent_event <= 1'b0;
		wait_fault(1'b1);
		$display("test limits done");
	endtask : t_limits

	// ----------------------------------------
	// main sequence and hang guard
	// ----------------------------------------
	initial begin
		repeat (100000) @(posedge pclk);
		fail_count++;
		give_verdict();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ccw_block_input, cw_block_input, fast_input_one, step_in, dir_in} = '0;
		{overcurrent_event, fault_event} = '0;
		hw_enable_input = 1'b1;
		fault_code = 4'h3;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_lines();
		t_marker();
		t_static();
		t_inhibit();
		t_fault();
		t_limits();
		give_verdict();
	end
endmodule : servo_drive_motion_config_tb
